// [inc/bor_pkg.sv]
// Package with register map, field layout, bus constants and voltage table
package bor_pkg;
  // ----------------------------------------
  // Serial slave address and transfer sizes
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h5b;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_OUTPUT_VOLTAGE_CONFIG   = 8'h10;
  localparam logic [7:0] OFS_OPERATING_MODE_SELECT   = 8'h11;
  localparam logic [7:0] OFS_RESERVED_READONLY       = 8'h12;
  localparam logic [7:0] OFS_ENABLE_AND_POWER_STATUS = 8'h13;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CODE_MSB       = 5;
  localparam int RANGE_BIT      = 6;
  localparam int MODE_BIT       = 0;
  localparam int ENABLE_BIT     = 0;
  localparam int PWR_OK_BIT     = 1;
  localparam int WRITE_EXACT_BIT = 2;

  // ----------------------------------------
  // Reset values (loaded by the register file on reset)
  // ----------------------------------------
  localparam logic [5:0] RST_CODE        = 6'h00;
  localparam logic       RST_RANGE       = 1'b1;
  localparam logic       RST_MODE        = 1'b0;
  localparam logic       RST_ENABLE      = 1'b0;
  localparam logic       RST_WRITE_EXACT = 1'b0;
  // Value returned by every read-only filler bit
  localparam logic       RO_FILL         = 1'b0;

  // ----------------------------------------
  // Voltage decode, millivolts
  // ----------------------------------------
  localparam logic [12:0] HIGH_BASE_MV = 13'h04e2;
  localparam logic [12:0] HIGH_STEP_MV = 13'h0032;
  localparam logic [5:0]  LOW_FIRST_ROW  = 6'h10;
  localparam logic [5:0]  LOW_FIRST_CODE = 6'h12;
  // Low range targets for codes 16..63; first two entries are unavailable
  localparam logic [11:0] LOW_MV [0:47] = '{
    12'h000, 12'h000, 12'h44c, 12'h465, 12'h47e, 12'h497, 12'h4b0, 12'h4c9,
    12'h4e7, 12'h500, 12'h519, 12'h532, 12'h54b, 12'h564, 12'h57d, 12'h596,
    12'h5af, 12'h5c8, 12'h5e1, 12'h5fa, 12'h613, 12'h631, 12'h64a, 12'h663,
    12'h67c, 12'h695, 12'h6ae, 12'h6c7, 12'h6e0, 12'h6f9, 12'h712, 12'h72b,
    12'h744, 12'h762, 12'h77b, 12'h794, 12'h7ad, 12'h7c6, 12'h7df, 12'h7f8,
    12'h811, 12'h82a, 12'h843, 12'h85c, 12'h875, 12'h88e, 12'h898, 12'h8c5};

  // ----------------------------------------
  // Serial slave states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } bor_state_t;
endpackage

// [design/bor_regs.sv]
// Step-down regulator one control registers behind a two-wire serial slave
`timescale 1ns/1ps

module bor_regs (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Regulator status input
  input  wire logic        pwr_ok_in,
  // Regulator controls
  output logic [5:0]       voltage_code_out,
  output logic             range_select_out,
  output logic             forced_pwm_out,
  output logic             reg_enable_out,
  output logic             write_exact_out,
  // Decoded target
  output logic [12:0]      target_mv_out,
  output logic             target_valid_out
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [12:0] target_mv(input logic range, input logic [5:0] code);
    logic [5:0] idx;
    idx = code - bor_pkg::LOW_FIRST_ROW;
    if (range)
      target_mv = bor_pkg::HIGH_BASE_MV + 13'(code) * bor_pkg::HIGH_STEP_MV;
    else if (code >= bor_pkg::LOW_FIRST_CODE)
      target_mv = 13'(bor_pkg::LOW_MV[idx]);
    else
      target_mv = 13'h0000;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  bor_pkg::bor_state_t state_reg;
  bor_pkg::bor_state_t state_next;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic [7:0] ptr_reg;
  logic       oe_reg;
  logic [5:0] code_reg;
  logic       range_reg;
  logic       mode_reg;
  logic       enable_reg;
  logic       wexact_reg;
  logic [12:0] mv_reg;
  logic       valid_reg;

  // ----------------------------------------
  // Pin events and decode
  // ----------------------------------------
  wire        scl_rise  = scl_in & ~scl_d_reg;
  wire        scl_fall  = ~scl_in & scl_d_reg;
  wire        start_ev  = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
  wire        stop_ev   = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
  wire        byte_done = (cnt_reg == bor_pkg::BITS_PER_BYTE);
  wire        addr_hit  = (shift_reg[7:1] == bor_pkg::SLAVE_ADDR);
  wire        rd_req    = shift_reg[0];
  wire        wr_strobe = scl_fall & byte_done & (state_reg == bor_pkg::ST_WDATA);
  wire        sel_volt  = (ptr_reg == bor_pkg::OFS_OUTPUT_VOLTAGE_CONFIG);
  wire        sel_mode  = (ptr_reg == bor_pkg::OFS_OPERATING_MODE_SELECT);
  wire        sel_en    = (ptr_reg == bor_pkg::OFS_ENABLE_AND_POWER_STATUS);
  // Reserved bits read as a fixed fill; offset 0x12 has no storage at all
  wire [7:0]  rd_volt   = {bor_pkg::RO_FILL, range_reg, code_reg};
  wire [7:0]  rd_mode   = {{7{bor_pkg::RO_FILL}}, mode_reg};
  wire [7:0]  rd_en     = {{5{bor_pkg::RO_FILL}}, wexact_reg, pwr_ok_in, enable_reg};
  wire [7:0]  rd_data   = sel_volt ? rd_volt : sel_mode ? rd_mode :
                          sel_en ? rd_en : {8{bor_pkg::RO_FILL}};

  assign sda_out          = 1'b0;
  assign sda_oe_out       = oe_reg;
  assign voltage_code_out = code_reg;
  assign range_select_out = range_reg;
  assign forced_pwm_out   = mode_reg;
  assign reg_enable_out   = enable_reg;
  assign write_exact_out  = wexact_reg;
  assign target_mv_out    = mv_reg;
  assign target_valid_out = valid_reg;

  // ----------------------------------------
  // Slave sequencing
  // ----------------------------------------
  // Bits are taken on the SCL rise; the slave changes SDA only on the fall
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bor_pkg::ST_IDLE:      state_next = bor_pkg::ST_IDLE;
      bor_pkg::ST_ADDR:
        if (scl_fall && byte_done) begin
          if (!addr_hit)
            state_next = bor_pkg::ST_IDLE;
          else
            state_next = bor_pkg::ST_ADDR_ACK;
        end
      bor_pkg::ST_ADDR_ACK:
        if (scl_fall) begin
          state_next = rd_req ? bor_pkg::ST_RDATA : bor_pkg::ST_PTR;
        end
      bor_pkg::ST_PTR:
        if (scl_fall && byte_done) begin
          state_next = bor_pkg::ST_PTR_ACK;
        end
      bor_pkg::ST_PTR_ACK:
        if (scl_fall) begin
          state_next = bor_pkg::ST_WDATA;
        end
      bor_pkg::ST_WDATA:
        if (scl_fall && byte_done) begin
          state_next = bor_pkg::ST_WDATA_ACK;
        end
      bor_pkg::ST_WDATA_ACK:
        if (scl_fall) begin
          state_next = bor_pkg::ST_WDATA;
        end
      bor_pkg::ST_RDATA:
        if (scl_fall && byte_done) begin
          state_next = bor_pkg::ST_RDATA_ACK;
        end
      bor_pkg::ST_RDATA_ACK:
        // Master NACK ends the read on the rise; after an ACK the same register
        // reloads on the fall, so SDA never moves while SCL is high
        if (scl_rise && sda_in)
          state_next = bor_pkg::ST_IDLE;
        else if (scl_fall)
          state_next = bor_pkg::ST_RDATA;
    endcase
    if (stop_ev)
      state_next = bor_pkg::ST_IDLE;
    if (start_ev)
      state_next = bor_pkg::ST_ADDR;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_reg <= bor_pkg::ST_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  // ----------------------------------------
  // Shifter, bit count, SDA drive
  // ----------------------------------------
  wire entering_rd = (state_next == bor_pkg::ST_RDATA) && (state_reg != bor_pkg::ST_RDATA);
  wire rx_state    = (state_reg == bor_pkg::ST_ADDR) || (state_reg == bor_pkg::ST_PTR) ||
                     (state_reg == bor_pkg::ST_WDATA);
  wire ack_state   = (state_next == bor_pkg::ST_ADDR_ACK) || (state_next == bor_pkg::ST_PTR_ACK) ||
                     (state_next == bor_pkg::ST_WDATA_ACK);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || start_ev || stop_ev) begin
      cnt_reg <= 4'h0;
      oe_reg  <= 1'b0;
    end else if (entering_rd) begin
      shift_reg <= {rd_data[6:0], 1'b0};
      oe_reg    <= ~rd_data[7];
      cnt_reg   <= 4'h1;
    end else if (scl_fall) begin
      if (ack_state) begin
        oe_reg <= 1'b1;
      end else if (state_reg == bor_pkg::ST_RDATA && !byte_done) begin
        oe_reg    <= ~shift_reg[7];
        shift_reg <= {shift_reg[6:0], 1'b0};
        cnt_reg   <= cnt_reg + 4'h1;
      end else begin
        oe_reg  <= 1'b0;
        cnt_reg <= byte_done ? 4'h0 : cnt_reg;
      end
    end else if (scl_rise && rx_state && !byte_done) begin
      shift_reg <= {shift_reg[6:0], sda_in};
      cnt_reg   <= cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ptr_reg    <= bor_pkg::OFS_OUTPUT_VOLTAGE_CONFIG;
      code_reg   <= bor_pkg::RST_CODE;
      range_reg  <= bor_pkg::RST_RANGE;
      mode_reg   <= bor_pkg::RST_MODE;
      enable_reg <= bor_pkg::RST_ENABLE;
      wexact_reg <= bor_pkg::RST_WRITE_EXACT;
    end else begin
      if (scl_fall && byte_done && state_reg == bor_pkg::ST_PTR)
        ptr_reg <= shift_reg;
      // Only writable fields take data; read-only bits are dropped
      if (wr_strobe && sel_volt) begin
        code_reg  <= shift_reg[bor_pkg::CODE_MSB:0];
        range_reg <= shift_reg[bor_pkg::RANGE_BIT];
      end
      if (wr_strobe && sel_mode)
        mode_reg <= shift_reg[bor_pkg::MODE_BIT];
      if (wr_strobe && sel_en) begin
        enable_reg <= shift_reg[bor_pkg::ENABLE_BIT];
        wexact_reg <= shift_reg[bor_pkg::WRITE_EXACT_BIT];
      end
    end
  end

  // ----------------------------------------
  // Target voltage decode
  // ----------------------------------------
  // Unavailable low codes give zero with the valid flag low so the
  // converter never follows them
  wire low_ok = (code_reg >= bor_pkg::LOW_FIRST_CODE);
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mv_reg    <= 13'h0000;
      valid_reg <= 1'b0;
    end else begin
      mv_reg    <= target_mv(range_reg, code_reg);
      valid_reg <= range_reg | low_ok;
    end
  end

endmodule

// [dv/bor_regs_sva.sv]
// Checker of bus timing and control outputs of the register block
`timescale 1ns/1ps
module bor_regs_chk (
  // Clock, reset, bus pins and regulator status input
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  input wire logic        pwr_ok_in,
  // Regulator controls and decoded target
  input wire logic [5:0]  voltage_code_out,
  input wire logic        range_select_out,
  input wire logic        forced_pwm_out,
  input wire logic        reg_enable_out,
  input wire logic        write_exact_out,
  input wire logic [12:0] target_mv_out,
  input wire logic        target_valid_out
);
  logic [1:0] rst_d;
  logic [6:0] last_set;
  logic       hold;
  logic       low_rng;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  always_ff @(posedge mclk_in) begin
    rst_d <= {rst_d[0], sys_rst_in};
    last_set <= {range_select_out, voltage_code_out};
  end
  // Target lags its code by one edge, so only settled codes are judged
  assign hold = rst_d == 2'b00 && last_set == {range_select_out, voltage_code_out};
  assign low_rng = hold && !range_select_out;
  sda_low_only_a: assert property (!sda_out)
    else $error("data pin driven high");
  reset_vals_a: assert property (rst_d[0] |-> {voltage_code_out, range_select_out,
    forced_pwm_out, reg_enable_out, write_exact_out, sda_oe_out} == 11'h010)
    else $error("controls not at reset values");
  high_code_a: assert property (hold && range_select_out |-> target_valid_out &&
    target_mv_out == 13'h04e2 + 13'h0032 * {7'h00, voltage_code_out}) else $error("high target");
  low_gap_a: assert property (low_rng && voltage_code_out < 6'h12 |-> !target_valid_out)
    else $error("unavailable code valid");
  low_first_a: assert property (low_rng && voltage_code_out == 6'h12 |-> target_valid_out
    && target_mv_out == 13'h044c) else $error("low first target");
  low_top_a: assert property (low_rng && voltage_code_out == 6'h3f |-> target_valid_out
    && target_mv_out == 13'h08c5) else $error("low top target");
  ack_on_low_a: assert property (!rst_d[0] && $changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
  ctl_on_low_a: assert property (!rst_d[0] && $changed({voltage_code_out,
    range_select_out, forced_pwm_out, reg_enable_out}) |-> !scl_in) else $error("control moved");
endmodule
bind bor_regs bor_regs_chk u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .pwr_ok_in(pwr_ok_in), .voltage_code_out(voltage_code_out),
  .range_select_out(range_select_out), .forced_pwm_out(forced_pwm_out),
  .reg_enable_out(reg_enable_out), .write_exact_out(write_exact_out),
  .target_mv_out(target_mv_out), .target_valid_out(target_valid_out));

// [dv/bor_host.sv]
// Host model: two-wire master making single-byte register writes and one- or two-byte reads
`timescale 1ns/1ps
module bor_host (
  // Clock and resolved data line
  input  wire logic mclk_in,
  input  wire logic sda_in,
  // Bus drive, data only pulled low
  output logic      scl_out,
  output logic      sda_low_out
);
  logic [8:0] rx;
  logic       addr_ack;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Five cycles a phase clears the slave's one-sample minimum
  task automatic ph(input logic c, input logic d);
    repeat (5) @(negedge mclk_in);
    scl_out = c;
    sda_low_out = !d;
  endtask
  // MSB first; the ninth bit is pulled low when ack is set, else released
  task automatic xfer(input logic [7:0] b, input logic ack);
    logic [8:0] v;
    v = {b, !ack};
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, v[i]);
      ph(1'b1, v[i]);
      rx = {rx[7:0], sda_in};
    end
  endtask
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    ph(1'b1, 1'b0);
    xfer({a, 1'b0}, 1'b0);
    addr_ack = !rx[0];
    xfer(p, 1'b0);
    xfer(d, 1'b0);
    stop();
  endtask
  // With twice set the first byte is acknowledged and a second one is read
  task automatic rd(input logic [7:0] p, input logic twice, output logic [7:0] d,
                    output logic [7:0] d2);
    ph(1'b1, 1'b0);
    xfer({bor_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
    xfer(p, 1'b0);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    xfer({bor_pkg::SLAVE_ADDR, 1'b1}, 1'b0);
    xfer(8'hff, twice);
    d = rx[8:1];
    d2 = 8'h00;
    if (twice) begin
      xfer(8'hff, 1'b0);
      d2 = rx[8:1];
    end
    stop();
  endtask
endmodule

// [dv/test_buck_one_control_regs.sv]
// Testbench for the regulator one control registers
`timescale 1ns/1ps
module test_buck_one_control_regs;
  localparam logic [6:0] SA = bor_pkg::SLAVE_ADDR;
  logic        mclk_in;
  logic        sys_rst_in;
  logic        pwr_ok_in;
  logic        scl;
  logic        host_low;
  logic        sda;
  logic        sda_oe_out;
  logic [5:0]  code;
  logic [12:0] mv;
  logic        rng, pwm, en, we, valid;
  logic [7:0]  rd_val;
  logic [7:0]  rd_extra;
  int          errors;
  int          samples_checked;
  // Pulled-up data line: a released line reads high
  assign sda = !(host_low || sda_oe_out);
  bor_host h (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  bor_regs DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(sda_oe_out), .pwr_ok_in(pwr_ok_in), .voltage_code_out(code),
    .range_select_out(rng), .forced_pwm_out(pwm), .reg_enable_out(en),
    .write_exact_out(we), .target_mv_out(mv), .target_valid_out(valid));
  initial mclk_in = 1'b0;
  always #10 mclk_in = ~mclk_in;
  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
    h.rd(p, 1'b0, rd_val, rd_extra);
    check($sformatf("read %h", p), {5'h00, exp}, {5'h00, rd_val});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge mclk_in);
  endtask
  initial begin
    repeat (30000) @(posedge mclk_in);
    errors++;
    give_verdict();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    pwr_ok_in = 1'b1;
    do_reset();
    check("target", 13'h04e2, mv);
    check("ctl", 13'h0011, {8'h00, rng, pwm, en, we, valid});
    rchk(8'h10, 8'h40);
    $display("reset test done");
    h.wr(SA, 8'h10, 8'hff);
    rchk(8'h10, 8'h7f);
    check("target", 13'h1130, mv);
    h.wr(SA, 8'h10, 8'h11);
    check("valid", 13'h0000, {12'h000, valid});
    h.wr(SA, 8'h10, 8'h12);
    check("target", 13'h044c, mv);
    h.wr(SA, 8'h10, 8'h3f);
    check("target", 13'h08c5, mv);
    $display("voltage test done");
    h.wr(SA, 8'h11, 8'hff);
    rchk(8'h11, 8'h01);
    h.wr(SA, 8'h12, 8'hff);
    rchk(8'h12, 8'h00);
    h.wr(SA, 8'h13, 8'hf9);
    rchk(8'h13, 8'h03);
    pwr_ok_in = 1'b0;
    rchk(8'h13, 8'h01);
    h.rd(8'h13, 1'b1, rd_val, rd_extra);
    check("repeat first", 13'h0001, {5'h00, rd_val});
    check("repeat second", 13'h0001, {5'h00, rd_extra});
    check("ctl", 13'h000d, {8'h00, rng, pwm, en, we, valid});
    $display("status test done");
    h.wr(7'h5a, 8'h11, 8'h00);
    check("ack", 13'h0000, {12'h000, h.addr_ack});
    rchk(8'h11, 8'h01);
    h.wr(SA, 8'h11, 8'h00);
    check("ack", 13'h0001, {12'h000, h.addr_ack});
    rchk(8'h11, 8'h00);
    $display("address test done");
    do_reset();
    check("ctl", 13'h0011, {8'h00, rng, pwm, en, we, valid});
    $display("second reset test done");
    give_verdict();
  end
endmodule
